/* common/gmc_pkg.sv */
// constants and reset contents for the gauge mode/control register bank
// Behaviour
// [R1] mode bit0: 0 mixed, 1 voltage-only; reset 1
// [R2] mode bit1 connects battery-detect pull-up; reset 1
// [R3] mode bit2 forces charger output high; reset 0
// [R4] mode bit4: 0 standby freezes, 1 operates
// [R5] mode bit5 forces counter state, relax=0, self-clears
// [R6] mode bit6 forces voltage state, relax=max, self-clears
// [R7] control bit0 read returns sampled alarm pin
// [R8] control bit0 write: 0 pulls alarm low
// [R9] control bit1 write 1 clears conversion counter
// [R10] control bit2 reads state-of-charge source path
// [R11] control bit3 battery removed; clear only pin low
// [R12] control bit4 reads power-on flag, 1 after power-up
// [R13] control bit4 write: 1 soft reset, 0 clears flag
// [R14] control bit5 latches low-charge alarm until write 0
// [R15] bits6/7 latch low-voltage, undervoltage until write 0
// [R16] sixteen SOC/OCV table pairs with default contents
// [R17] OCV point two bytes, SOC point one byte
// [R18] every register returns to default on reset
// [R19] low byte first; pairs read consistently
// [R20] mode bit3 alarm enable reset 1; bit7 zero
// [R21] self-clearing bits act once per written 1
package gmc_pkg;
   localparam logic [7:0] MODE_ADDR     = 8'h00;
   localparam logic [7:0] CTRL_ADDR     = 8'h01;
   localparam logic [7:0] OCV_TAB_ADDR  = 8'h30;
   localparam logic [7:0] SOC_TAB_ADDR  = 8'h50;
   localparam int         TABLE_POINTS  = 16;

   // mode register fields
   localparam int MODE_VOLT_ONLY   = 0;
   localparam int MODE_DETECT_PU   = 1;
   localparam int MODE_CHG_FORCE   = 2;
   localparam int MODE_ALARM_EN    = 3;
   localparam int MODE_OPERATE     = 4;
   localparam int MODE_FORCE_CNT   = 5;
   localparam int MODE_FORCE_VOLT  = 6;
   localparam logic [4:0] MODE_RESET = 5'h0B;

   // control register fields
   localparam int CTRL_ALARM_IO    = 0;
   localparam int CTRL_CONV_CLEAR  = 1;
   localparam int CTRL_SOC_SOURCE  = 2;
   localparam int CTRL_BAT_REMOVED = 3;
   localparam int CTRL_POWER_ON    = 4;
   localparam int CTRL_LOW_CHARGE  = 5;
   localparam int CTRL_LOW_VOLT    = 6;
   localparam int CTRL_UNDERVOLT   = 7;

   localparam logic [7:0] RELAX_ZERO = 8'h00;
   localparam logic [7:0] RELAX_MAX  = 8'hFF;

   localparam logic [7:0] SOC_DEFAULT [TABLE_POINTS] = '{
      8'h00, 8'h06, 8'h0C, 8'h14, 8'h1E, 8'h28, 8'h32, 8'h3C,
      8'h50, 8'h64, 8'h78, 8'h82, 8'h8C, 8'hA0, 8'hB4, 8'hC8};
   localparam logic [15:0] OCV_DEFAULT [TABLE_POINTS] = '{
      16'h1770, 16'h1926, 16'h19B2, 16'h19FB, 16'h1A3E, 16'h1A6D, 16'h1A9D, 16'h1AB6,
      16'h1AD5, 16'h1B01, 16'h1B70, 16'h1BB1, 16'h1BE8, 16'h1C58, 16'h1CF3, 16'h1DA9};
endpackage : gmc_pkg

/* verilog/gmc_mode_control_regs.sv */
// mode/control/status registers and SOC-OCV table of the gas gauge
module gmc_mode_control_regs
(
   input  wire logic       sys_clk,             // system clock, 100 MHz
   input  wire logic       reset,               // async reset, active high
   input  wire logic [7:0] regAddr,             // register byte address
   input  wire logic       regWrite,            // one-cycle write strobe
   input  wire logic [7:0] regWriteData,        // write byte
   input  wire logic       regRead,             // one-cycle read strobe
   input  wire logic       regReadFirst,        // first byte of a host transaction
   output logic      [7:0] regReadData,         // read byte, valid cycle after strobe
   input  wire logic       alarmPinIn,          // alarm pin level (async)
   output logic            alarmPinOut,         // alarm pin drive value, always 0
   output logic            alarmPinOe_n,        // low while pulling alarm pin low
   input  wire logic       batteryDetectPin,    // battery-detect pin (async)
   output logic            batteryDetectPullupEn, // pull-up on battery-detect pin
   input  wire logic       chargerLogicLevel,   // charger level from internal logic
   output logic            chargerControlOut,   // charger-control pin
   output logic            voltageOnlySelect,   // 1 voltage-only, 0 mixed mode
   output logic            gaugeOperate,        // 0 standby, 1 operate
   output logic            alarmFunctionEnable, // alarm function enabled
   output logic            forceCounterState,   // pulse: relax fsm to counter state
   output logic            forceVoltageState,   // pulse: relax fsm to voltage state
   output logic            relaxCounterLoad,    // pulse: load relax counter
   output logic      [7:0] relaxCounterValue,   // value to load
   output logic            conversionCountClear, // pulse: clear conversion counter
   output logic            softResetPulse,      // pulse: soft reset of the gauge
   input  wire logic       socSourceVoltage,    // 1 SOC from voltage path
   input  wire logic       lowChargeEvent,      // low SOC alarm condition
   input  wire logic       lowVoltageEvent,     // low voltage alarm condition
   input  wire logic       undervoltageEvent,   // undervoltage lockout event
   input  wire logic [3:0] tableIndex,          // table point for the gauge
   output logic      [7:0] tableSoc,            // SOC of that point
   output logic     [15:0] tableOcv             // OCV of that point
);
   import gmc_pkg::*;

   logic [4:0]  mode_ff;
   logic        alarmDrive_ff;
   logic        batRemoved_ff;
   logic        powerOn_ff;
   logic        lowCharge_ff;
   logic        lowVolt_ff;
   logic        underVolt_ff;
   logic [1:0]  alarmSync_ff;
   logic [1:0]  batSync_ff;
   logic [7:0]  socTab_ff [TABLE_POINTS];
   logic [15:0] ocvTab_ff [TABLE_POINTS];
   logic [7:0]  readData_ff;
   logic [7:0]  shadowHigh_ff;
   logic [7:0]  shadowAddr_ff;
   logic        shadowValid_ff;
   logic        forceCnt_ff;
   logic        forceVolt_ff;
   logic        convClear_ff;
   logic        softReset_ff;
   logic [7:0]  relaxValue_ff;
   logic [7:0]  tableSoc_ff;
   logic [15:0] tableOcv_ff;

   logic modeWrite;
   logic ctrlWrite;
   logic swReset;
   logic alarmPinLevel;
   logic batPinLevel;
   logic alarmCondition;

   // ocv byte address -> table point and byte half
   function automatic logic isOcvAddr(input logic [7:0] a);
      isOcvAddr = (a >= OCV_TAB_ADDR) && (a < SOC_TAB_ADDR);
   endfunction : isOcvAddr

   function automatic logic isSocAddr(input logic [7:0] a);
      isSocAddr = (a >= SOC_TAB_ADDR) && (a < SOC_TAB_ADDR + 8'(TABLE_POINTS));
   endfunction : isSocAddr

   function automatic logic [3:0] ocvPoint(input logic [7:0] a);
      logic [7:0] d;
      d = a - OCV_TAB_ADDR;
      ocvPoint = d[4:1];
   endfunction : ocvPoint

   function automatic logic [3:0] socPoint(input logic [7:0] a);
      logic [7:0] d;
      d = a - SOC_TAB_ADDR;
      socPoint = d[3:0];
   endfunction : socPoint

   assign modeWrite     = regWrite && (regAddr == MODE_ADDR);
   assign ctrlWrite     = regWrite && (regAddr == CTRL_ADDR);
   assign swReset       = ctrlWrite && regWriteData[CTRL_POWER_ON];         // [R13]
   assign alarmPinLevel = alarmSync_ff[1];
   assign batPinLevel   = batSync_ff[1];

   // pins are asynchronous to sys_clk
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         alarmSync_ff <= 2'h0;
         batSync_ff   <= 2'h0;
      end
      else
      begin
         alarmSync_ff <= {alarmSync_ff[0], alarmPinIn};
         batSync_ff   <= {batSync_ff[0], batteryDetectPin};
      end
   end

   // mode register
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         mode_ff <= MODE_RESET;                                          // [R18]
      else if (swReset)
         mode_ff <= MODE_RESET;                                          // [R18]
      else if (modeWrite)
         mode_ff <= regWriteData[4:0];                                   // [R1] [R2] [R3] [R4] [R20]
   end

   // self-clearing commands: one pulse per written 1, never stored
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         forceCnt_ff   <= 1'b0;
         forceVolt_ff  <= 1'b0;
         convClear_ff  <= 1'b0;
         softReset_ff  <= 1'b0;
         relaxValue_ff <= RELAX_ZERO;
      end
      else
      begin
         forceCnt_ff  <= modeWrite && regWriteData[MODE_FORCE_CNT];       // [R5] [R21]
         forceVolt_ff <= modeWrite && regWriteData[MODE_FORCE_VOLT];      // [R6] [R21]
         convClear_ff <= ctrlWrite && regWriteData[CTRL_CONV_CLEAR];      // [R9] [R21]
         softReset_ff <= swReset;                                        // [R13] [R21]
         // voltage state wins if both are written together
         if (modeWrite && regWriteData[MODE_FORCE_VOLT])
            relaxValue_ff <= RELAX_MAX;                                  // [R6]
         else if (modeWrite && regWriteData[MODE_FORCE_CNT])
            relaxValue_ff <= RELAX_ZERO;                                 // [R5]
      end
   end

   // alarm pin drive enable
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         alarmDrive_ff <= 1'b1;                                          // [R18]
      else if (swReset)
         alarmDrive_ff <= 1'b1;
      else if (ctrlWrite)
         alarmDrive_ff <= regWriteData[CTRL_ALARM_IO];                   // [R8]
   end

   // power-on flag: set by reset and soft reset, cleared by writing 0
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         powerOn_ff <= 1'b1;                                             // [R12]
      else if (ctrlWrite)
         powerOn_ff <= regWriteData[CTRL_POWER_ON];                      // [R13]
   end

   // sticky flags: an event in the clearing cycle wins
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         batRemoved_ff <= 1'b0;
         lowCharge_ff  <= 1'b0;
         lowVolt_ff    <= 1'b0;
         underVolt_ff  <= 1'b0;
      end
      else if (swReset)
      begin
         batRemoved_ff <= batPinLevel;
         lowCharge_ff  <= lowChargeEvent;
         lowVolt_ff    <= lowVoltageEvent;
         underVolt_ff  <= undervoltageEvent;
      end
      else
      begin
         if (batPinLevel)
            batRemoved_ff <= 1'b1;                                       // [R11]
         else if (ctrlWrite && !regWriteData[CTRL_BAT_REMOVED])
            batRemoved_ff <= 1'b0;                                       // [R11]
         if (lowChargeEvent)
            lowCharge_ff <= 1'b1;                                        // [R14]
         else if (ctrlWrite && !regWriteData[CTRL_LOW_CHARGE])
            lowCharge_ff <= 1'b0;                                        // [R14]
         if (lowVoltageEvent)
            lowVolt_ff <= 1'b1;                                          // [R15]
         else if (ctrlWrite && !regWriteData[CTRL_LOW_VOLT])
            lowVolt_ff <= 1'b0;                                          // [R15]
         if (undervoltageEvent)
            underVolt_ff <= 1'b1;                                        // [R15]
         else if (ctrlWrite && !regWriteData[CTRL_UNDERVOLT])
            underVolt_ff <= 1'b0;                                        // [R15]
      end
   end

   // soc/ocv table, one write per byte, low byte at lower address
   genvar gi;
   generate
      for (gi = 0; gi < TABLE_POINTS; gi++)
      begin : gTable
         always_ff @(posedge sys_clk or posedge reset)
         begin
            if (reset)
            begin
               socTab_ff[gi] <= SOC_DEFAULT[gi];                         // [R16] [R18]
               ocvTab_ff[gi] <= OCV_DEFAULT[gi];                         // [R16] [R18]
            end
            else if (swReset)
            begin
               socTab_ff[gi] <= SOC_DEFAULT[gi];
               ocvTab_ff[gi] <= OCV_DEFAULT[gi];
            end
            else if (regWrite)
            begin
               if (isSocAddr(regAddr) && socPoint(regAddr) == 4'(gi))
                  socTab_ff[gi] <= regWriteData;                         // [R17]
               if (isOcvAddr(regAddr) && ocvPoint(regAddr) == 4'(gi))
               begin
                  if (regAddr[0] == OCV_TAB_ADDR[0])
                     ocvTab_ff[gi][7:0] <= regWriteData;                 // [R17] [R19]
                  else
                     ocvTab_ff[gi][15:8] <= regWriteData;                // [R17] [R19]
               end
            end
         end
      end
   endgenerate

   // read port; high byte of a pair read right after its low byte in the same transaction comes from the snapshot taken with the low byte
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         readData_ff    <= 8'h00;
         shadowHigh_ff  <= 8'h00;
         shadowAddr_ff  <= 8'h00;
         shadowValid_ff <= 1'b0;
      end
      else if (regRead)
      begin
         shadowValid_ff <= 1'b0;
         if (regAddr == MODE_ADDR)
            readData_ff <= {3'h0, mode_ff};                              // [R20] [R21]
         else if (regAddr == CTRL_ADDR)
            readData_ff <= {underVolt_ff, lowVolt_ff, lowCharge_ff, powerOn_ff,
                            batRemoved_ff, socSourceVoltage, 1'b0, alarmPinLevel}; // [R7] [R10] [R12]
         else if (isSocAddr(regAddr))
            readData_ff <= socTab_ff[socPoint(regAddr)];
         else if (isOcvAddr(regAddr) && regAddr[0] == OCV_TAB_ADDR[0])
         begin
            readData_ff    <= ocvTab_ff[ocvPoint(regAddr)][7:0];
            shadowHigh_ff  <= ocvTab_ff[ocvPoint(regAddr)][15:8];        // [R19]
            shadowAddr_ff  <= regAddr + 8'h01;
            shadowValid_ff <= 1'b1;
         end
         else if (isOcvAddr(regAddr))
         begin
            if (shadowValid_ff && !regReadFirst && shadowAddr_ff == regAddr)
               readData_ff <= shadowHigh_ff;                             // [R19]
            else
               readData_ff <= ocvTab_ff[ocvPoint(regAddr)][15:8];
         end
         else
            readData_ff <= 8'h00;
      end
   end

   // table lookup for the gauge; registered to keep the data path clean
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         tableSoc_ff <= 8'h00;
         tableOcv_ff <= 16'h0000;
      end
      else
      begin
         tableSoc_ff <= socTab_ff[tableIndex];
         tableOcv_ff <= ocvTab_ff[tableIndex];
      end
   end

   // alarm pin is active low, open drain
   assign alarmCondition = mode_ff[MODE_ALARM_EN] &&
                           (lowCharge_ff || lowVolt_ff || batRemoved_ff);   // [R20]
   assign alarmPinOut    = 1'b0;
   assign alarmPinOe_n   = alarmDrive_ff && !alarmCondition;              // [R8]

   assign regReadData           = readData_ff;
   assign voltageOnlySelect     = mode_ff[MODE_VOLT_ONLY];                // [R1]
   assign batteryDetectPullupEn = mode_ff[MODE_DETECT_PU];                // [R2]
   assign chargerControlOut     = mode_ff[MODE_CHG_FORCE] | chargerLogicLevel; // [R3]
   assign alarmFunctionEnable   = mode_ff[MODE_ALARM_EN];                 // [R20]
   assign gaugeOperate          = mode_ff[MODE_OPERATE];                  // [R4]
   assign forceCounterState     = forceCnt_ff;
   assign forceVoltageState     = forceVolt_ff;
   assign relaxCounterLoad      = forceCnt_ff | forceVolt_ff;
   assign relaxCounterValue     = relaxValue_ff;
   assign conversionCountClear  = convClear_ff;
   assign softResetPulse        = softReset_ff;
   assign tableSoc              = tableSoc_ff;
   assign tableOcv              = tableOcv_ff;
endmodule : gmc_mode_control_regs

/* dv/gmc_regs_properties.sv */
// port assertions for the gauge mode/control register bank
module gmc_regs_properties
   import gmc_pkg::*;
(
   input wire logic       sys_clk,              // clock
   input wire logic       reset,                // async reset
   input wire logic [7:0] regAddr,              // address
   input wire logic       regWrite,             // write strobe
   input wire logic [7:0] regWriteData,         // write byte
   input wire logic       regRead,              // read strobe
   input wire logic [7:0] regReadData,          // read byte
   input wire logic       alarmPinOe_n,         // alarm pull-low
   input wire logic       chargerLogicLevel,    // charger logic
   input wire logic       chargerControlOut,    // charger pin
   input wire logic       voltageOnlySelect,    // mode bit0
   input wire logic       gaugeOperate,         // mode bit4
   input wire logic       forceCounterState,    // force pulse
   input wire logic       forceVoltageState,    // force pulse
   input wire logic       relaxCounterLoad,     // load pulse
   input wire logic [7:0] relaxCounterValue,    // load value
   input wire logic       conversionCountClear, // clear pulse
   input wire logic       softResetPulse        // soft reset
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence modeWr;
      regWrite && regAddr == MODE_ADDR;
   endsequence
   sequence ctrlWr;
      regWrite && regAddr == CTRL_ADDR;
   endsequence

   relax_load_a: assert property (forceCounterState && !forceVoltageState |-> relaxCounterLoad
                                  && relaxCounterValue == RELAX_ZERO)
      else $error("counter state force without zero load");
   force_cnt_a: assert property (modeWr ##0 regWriteData[5] |=> forceCounterState)
      else $error("counter state force missing");
   force_volt_a: assert property (modeWr ##0 regWriteData[6] |=> forceVoltageState
                                  && relaxCounterLoad && relaxCounterValue == RELAX_MAX)
      else $error("voltage state force or max load missing");
   volt_once_a: assert property (!(regWrite && regAddr == MODE_ADDR && regWriteData[6]) |=> !forceVoltageState)
      else $error("spurious voltage state force");
   ctrl_cmd_a: assert property (ctrlWr |=> conversionCountClear == $past(regWriteData[1])
                                && softResetPulse == $past(regWriteData[4]))
      else $error("control command pulse mismatch");
   cmd_idle_a: assert property (!regWrite |=> !conversionCountClear && !softResetPulse)
      else $error("command pulse without write");
   alarm_low_a: assert property (ctrlWr ##0 (!regWriteData[0] && !regWriteData[4]) |=> !alarmPinOe_n)
      else $error("alarm pin not forced low");
   charger_out_a: assert property (chargerLogicLevel |-> chargerControlOut)
      else $error("charger output ignores logic level");
   mode_apply_a: assert property (modeWr |=> gaugeOperate == $past(regWriteData[4])
                                  && voltageOnlySelect == $past(regWriteData[0]))
      else $error("mode bits not applied");
   mode_read_a: assert property (regRead && regAddr == MODE_ADDR |=> regReadData[7:5] == 3'h0)
      else $error("mode upper bits read nonzero");
endmodule : gmc_regs_properties

bind gmc_mode_control_regs gmc_regs_properties u_props (.sys_clk, .reset, .regAddr, .regWrite, .regWriteData,
   .regRead, .regReadData, .alarmPinOe_n, .chargerLogicLevel, .chargerControlOut, .voltageOnlySelect,
   .gaugeOperate, .forceCounterState, .forceVoltageState, .relaxCounterLoad, .relaxCounterValue,
   .conversionCountClear, .softResetPulse);

/* dv/gmc_host_model.sv */
// host processor model issuing byte register accesses
module gmc_host_model
(
   input  wire logic       sys_clk,      // clock
   output logic      [7:0] regAddr,      // address
   output logic            regWrite,     // write strobe
   output logic      [7:0] regWriteData, // write byte
   output logic            regRead,      // read strobe
   output logic            regReadFirst, // transaction start
   input  wire logic [7:0] regReadData   // read byte
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regWriteData = 8'h00;
      regRead = 1'b0;
      regReadFirst = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      @(posedge sys_clk);
      #1;
      regWrite = 1'b0;
      // released bus shows garbage, not the last value
      regAddr = ~a;
      regWriteData = ~d;
   endtask : wr
   // second byte of a pair goes with first=0 in the same transaction
   task automatic rd(input logic [7:0] a, input logic first, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      regAddr = a;
      regReadFirst = first;
      regRead = 1'b1;
      @(posedge sys_clk);
      #1;
      d = regReadData;
      regRead = 1'b0;
      regAddr = ~a;
   endtask : rd
endmodule : gmc_host_model

/* dv/testbench.sv */
// self-checking bench for the gauge mode/control register bank
module testbench
   import gmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        alarmExt = 1'b1;
   logic        batteryDetectPin = 1'b0;
   logic        chargerLogicLevel = 1'b0;
   logic        socSourceVoltage = 1'b0;
   logic        lowChargeEvent = 1'b0;
   logic        lowVoltageEvent = 1'b0;
   logic        undervoltageEvent = 1'b0;
   logic [3:0]  tableIndex = 4'h0;
   logic [7:0]  regAddr, regWriteData, regReadData, rdByte, hiByte, relaxCounterValue, tableSoc;
   logic        regWrite, regRead, regReadFirst, alarmPinOut, alarmPinOe_n, batteryDetectPullupEn;
   logic        chargerControlOut, voltageOnlySelect, gaugeOperate, alarmFunctionEnable;
   logic        forceCounterState, forceVoltageState, relaxCounterLoad, conversionCountClear, softResetPulse;
   logic [15:0] tableOcv;
   wire         alarmPinIn = alarmExt & (alarmPinOe_n | alarmPinOut);
   int          errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   always #5 sys_clk = ~sys_clk;

   gmc_host_model u_host (.sys_clk, .regAddr, .regWrite, .regWriteData, .regRead, .regReadFirst, .regReadData);
   gmc_mode_control_regs u_dut (.sys_clk, .reset, .regAddr, .regWrite, .regWriteData, .regRead, .regReadFirst,
      .regReadData, .alarmPinIn, .alarmPinOut, .alarmPinOe_n, .batteryDetectPin, .batteryDetectPullupEn,
      .chargerLogicLevel, .chargerControlOut, .voltageOnlySelect, .gaugeOperate, .alarmFunctionEnable,
      .forceCounterState, .forceVoltageState, .relaxCounterLoad, .relaxCounterValue, .conversionCountClear,
      .softResetPulse, .socSourceVoltage, .lowChargeEvent, .lowVoltageEvent, .undervoltageEvent,
      .tableIndex, .tableSoc, .tableOcv);

   task automatic end_sim();
      $display("compares=%0d errors=%0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         end_sim();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, 1'b1, rdByte);
      chk({8'h00, rdByte}, {8'h00, e});
   endtask : rdc
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic t_reset();
      chk({12'h000, voltageOnlySelect, batteryDetectPullupEn, gaugeOperate, alarmFunctionEnable}, 16'h000D);
      rdc(MODE_ADDR, 8'h0B);
      rdc(CTRL_ADDR, 8'h11);
      rdc(8'h20, 8'h00);
      u_host.wr(8'h20, 8'hFF);
      rdc(8'h20, 8'h00);
   endtask : t_reset

   task automatic t_table();
      for (int i = 0; i < TABLE_POINTS; i++)
      begin
         tableIndex = i[3:0];
         u_host.rd(OCV_TAB_ADDR + 8'(2 * i), 1'b1, rdByte);
         u_host.rd(OCV_TAB_ADDR + 8'(2 * i + 1), 1'b0, hiByte);
         chk({hiByte, rdByte}, OCV_DEFAULT[i]);
         rdc(SOC_TAB_ADDR + 8'(i), SOC_DEFAULT[i]);
         chk({8'h00, tableSoc}, {8'h00, SOC_DEFAULT[i]});
         chk(tableOcv, OCV_DEFAULT[i]);
      end
      u_host.rd(8'h36, 1'b1, rdByte);
      u_host.wr(8'h37, 8'h55);
      u_host.rd(8'h37, 1'b0, hiByte);
      chk({hiByte, rdByte}, 16'h19FB);
      rdc(8'h37, 8'h55);
      tableIndex = 4'h3;
      u_host.wr(SOC_TAB_ADDR + 8'h03, 8'hA5);
      rdc(SOC_TAB_ADDR + 8'h03, 8'hA5);
      chk({8'h00, tableSoc}, 16'h00A5);
   endtask : t_table

   task automatic t_ctrl();
      u_host.wr(CTRL_ADDR, 8'hE9);
      rdc(CTRL_ADDR, 8'h01);
      {lowChargeEvent, lowVoltageEvent, undervoltageEvent} = 3'h7;
      tick(1);
      {lowChargeEvent, lowVoltageEvent, undervoltageEvent} = 3'h0;
      tick(3);
      rdc(CTRL_ADDR, 8'hE0);
      u_host.wr(CTRL_ADDR, 8'h01);
      tick(3);
      rdc(CTRL_ADDR, 8'h01);
      batteryDetectPin = 1'b1;
      tick(3);
      u_host.wr(CTRL_ADDR, 8'h01);
      rdc(CTRL_ADDR, 8'h08);
      batteryDetectPin = 1'b0;
      tick(3);
      u_host.wr(CTRL_ADDR, 8'h01);
      tick(3);
      rdc(CTRL_ADDR, 8'h01);
      u_host.wr(CTRL_ADDR, 8'h00);
      chk(alarmPinOe_n, 1'b0);
      tick(3);
      rdc(CTRL_ADDR, 8'h00);
      socSourceVoltage = 1'b1;
      u_host.wr(CTRL_ADDR, 8'h03);
      chk(conversionCountClear, 1'b1);
      tick(3);
      chk(conversionCountClear, 1'b0);
      rdc(CTRL_ADDR, 8'h05);
      // pin held low from outside while the block releases it
      alarmExt = 1'b0;
      tick(3);
      rdc(CTRL_ADDR, 8'h04);
      alarmExt = 1'b1;
      tick(3);
   endtask : t_ctrl

   task automatic t_mode();
      u_host.wr(MODE_ADDR, 8'h14);
      chk({gaugeOperate, voltageOnlySelect, batteryDetectPullupEn, alarmFunctionEnable}, 4'h8);
      chk(chargerControlOut, 1'b1);
      u_host.wr(MODE_ADDR, 8'h20);
      chk({forceCounterState, relaxCounterLoad, relaxCounterValue}, 10'h300);
      u_host.wr(MODE_ADDR, 8'h5F);
      chk({forceVoltageState, relaxCounterLoad, relaxCounterValue}, 10'h3FF);
      tick(1);
      chk({forceCounterState, forceVoltageState, relaxCounterLoad}, 3'h0);
      rdc(MODE_ADDR, 8'h1F);
      u_host.wr(MODE_ADDR, 8'h10);
      chargerLogicLevel = 1'b1;
      tick(1);
      chk(chargerControlOut, 1'b1);
      chargerLogicLevel = 1'b0;
      tick(1);
      chk(chargerControlOut, 1'b0);
   endtask : t_mode

   task automatic t_soft();
      u_host.wr(CTRL_ADDR, 8'h11);
      chk(softResetPulse, 1'b1);
      tick(2);
      rdc(MODE_ADDR, 8'h0B);
      rdc(CTRL_ADDR, 8'h15);
      rdc(8'h37, 8'h19);
      rdc(SOC_TAB_ADDR + 8'h03, SOC_DEFAULT[3]);
   endtask : t_soft

   initial
   begin
      repeat (12) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      t_reset();
      t_table();
      t_ctrl();
      t_mode();
      t_soft();
      end_sim();
   end
endmodule : testbench
